// File: shared/urd_params.svh
// timing constants for the upstream port reset detection and handshake logic
`ifndef URD_PARAMS_SVH
`define URD_PARAMS_SVH
`define URD_CLK_MHZ 100
`define URD_TIMER_W 20
// times in ns as printed, counts derived at 10 ns per cycle
`define URD_SUSPEND_NS 3000000
`define URD_SUSPEND_CYC (((`URD_SUSPEND_NS) * `URD_CLK_MHZ) / 1000)
`define URD_FS_RST_WAIT_NS 100000
`define URD_FS_RST_WAIT_CYC (((`URD_FS_RST_WAIT_NS) * `URD_CLK_MHZ + 999) / 1000)
`define URD_HS_REV_NS 3062500
`define URD_HS_REV_CYC (((`URD_HS_REV_NS) * `URD_CLK_MHZ + 999) / 1000)
`define URD_SETTLE_NS 100000
`define URD_SETTLE_CYC (((`URD_SETTLE_NS) * `URD_CLK_MHZ + 999) / 1000)
`define URD_UCH_NS 1500000
`define URD_UCH_CYC (((`URD_UCH_NS) * `URD_CLK_MHZ + 999) / 1000)
`define URD_UCHEND_NS 7000000
`define URD_UCHEND_CYC (((`URD_UCHEND_NS) * `URD_CLK_MHZ) / 1000)
`define URD_WTFS_NS 2000000
`define URD_WTFS_CYC (((`URD_WTFS_NS) * `URD_CLK_MHZ) / 1000)
`define URD_FILT_NS 2500
`define URD_FILT_CYC (((`URD_FILT_NS) * `URD_CLK_MHZ + 999) / 1000)
`define URD_KJ_NEEDED 3
`endif

// File: shared/urd_pkg.sv
// types for the upstream port reset detection and handshake logic
package urd_pkg;
    typedef enum logic [1:0] {
        URD_LS_SE0 = 2'b00,
        URD_LS_J = 2'b01,
        URD_LS_K = 2'b10,
        URD_LS_SE1 = 2'b11
    } urd_line_e;

    typedef enum logic [3:0] {
        URD_FS_RUN = 4'h0,
        URD_FS_WAIT = 4'h1,
        URD_HS_RUN = 4'h2,
        URD_HS_WAIT = 4'h3,
        URD_SETTLE = 4'h4,
        URD_SUSPEND = 4'h5,
        URD_CHIRP = 4'h6,
        URD_DS_K = 4'h7,
        URD_DS_J = 4'h8,
        URD_FS_DEF = 4'h9,
        URD_HS_DEF = 4'ha
    } urd_state_e;

    typedef struct packed {
        logic hs_term_en;
        logic dp_pullup_en;
        logic chirp_k_drive;
    } urd_xcvr_s;

    typedef struct packed {
        logic suspended;
        logic resume_req;
        logic fs_default;
        logic hs_default;
        logic reset_done;
    } urd_stat_s;
endpackage

// File: hw/urd_timer.sv
// free counter with a start (clear then run) and a saturating count
`include "urd_params.svh"
module urd_timer
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    output logic [`URD_TIMER_W-1:0] count
);
    localparam logic [`URD_TIMER_W-1:0] MAX_CNT = '1;

    // saturates so a long-idle timer never wraps into a false threshold
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (start)
            count <= '0;
        else if (count != MAX_CNT)
            count <= count + 1'b1;
    end
endmodule

// File: hw/urd_top.sv
// reset detection and speed handshake for the upstream facing port
// Summary of operation
// - fs idle or se0 starts reset timer
// - fs idle held past 3 ms suspends
// - fs se0 held wait time starts handshake
// - fs line change aborts, restores state
// - hs idle starts timer; non-idle aborts
// - past reversion time, fs terminations, pull-up
// - settle, sample: idle suspends, se0 handshakes
// - sampled k: suspend, resume to hs
// - chirp k at least 1 ms, before 7 ms
// - chirp ends on length timer or limit
// - downstream k/j filtered for 2.5 us
// - three filtered k-j transitions select hs
// - timeout with too few selects fs default
// - fs outcome ends at se0 to idle
// - success: hs terminations, no pull-up, hs default
// - terminations switch at once after third
// - hs outcome ends at first packet
// - timers clear on start, count each clock
`include "urd_params.svh"
module urd_top
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] line_state,
    input wire logic hs_mode_in,
    input wire logic packet_rx,
    output urd_pkg::urd_xcvr_s xcvr_r,
    output urd_pkg::urd_stat_s stat_r
);
    // every threshold is a cycle count picked inside its allowed range
    localparam logic [`URD_TIMER_W-1:0] SUSPEND_CYC = `URD_TIMER_W'(`URD_SUSPEND_CYC);
    localparam logic [`URD_TIMER_W-1:0] FS_WAIT_CYC = `URD_TIMER_W'(`URD_FS_RST_WAIT_CYC);
    localparam logic [`URD_TIMER_W-1:0] HS_REV_CYC = `URD_TIMER_W'(`URD_HS_REV_CYC);
    localparam logic [`URD_TIMER_W-1:0] SETTLE_CYC = `URD_TIMER_W'(`URD_SETTLE_CYC);
    localparam logic [`URD_TIMER_W-1:0] UCH_CYC = `URD_TIMER_W'(`URD_UCH_CYC);
    localparam logic [`URD_TIMER_W-1:0] UCHEND_CYC = `URD_TIMER_W'(`URD_UCHEND_CYC);
    localparam logic [`URD_TIMER_W-1:0] WTFS_CYC = `URD_TIMER_W'(`URD_WTFS_CYC);
    localparam logic [`URD_TIMER_W-1:0] FILT_CYC = `URD_TIMER_W'(`URD_FILT_CYC);
    localparam logic [1:0] KJ_NEEDED = 2'(`URD_KJ_NEEDED);

    // pins come from the analog transceiver, so they are synchronised
    logic [1:0] ls_meta_r;
    logic [1:0] ls_sync_r;
    logic [1:0] ls_prev_r;
    logic hs_meta_r;
    logic hs_sync_r;
    logic pkt_meta_r;
    logic pkt_sync_r;
    urd_pkg::urd_line_e ls;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ls_meta_r <= 2'h1;
            ls_sync_r <= 2'h1;
            ls_prev_r <= 2'h1;
            hs_meta_r <= 1'b0;
            hs_sync_r <= 1'b0;
            pkt_meta_r <= 1'b0;
            pkt_sync_r <= 1'b0;
        end
        else
        begin
            ls_meta_r <= line_state;
            ls_sync_r <= ls_meta_r;
            ls_prev_r <= ls_sync_r;
            hs_meta_r <= hs_mode_in;
            hs_sync_r <= hs_meta_r;
            pkt_meta_r <= packet_rx;
            pkt_sync_r <= pkt_meta_r;
        end
    end

    assign ls = urd_pkg::urd_line_e'(ls_sync_r);

    urd_pkg::urd_state_e state_r;
    urd_pkg::urd_state_e state_nxt;
    urd_pkg::urd_state_e prev_r;
    logic [1:0] kj_cnt_r;
    logic [`URD_TIMER_W-1:0] rst_cnt;
    logic [`URD_TIMER_W-1:0] chirp_cnt;
    logic [`URD_TIMER_W-1:0] ds_cnt;
    logic [`URD_TIMER_W-1:0] filt_cnt;
    logic rst_start;
    logic chirp_start;
    logic ds_start;
    logic filt_start;
    logic ls_changed;
    logic filt_ok;
    logic ds_timeout;

    assign ls_changed = (ls_sync_r != ls_prev_r);
    assign filt_ok = (filt_cnt >= FILT_CYC);
    assign ds_timeout = (ds_cnt >= WTFS_CYC);

    urd_timer u_rst_timer
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(rst_start),
        .count(rst_cnt)
    );

    urd_timer u_chirp_timer
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(chirp_start),
        .count(chirp_cnt)
    );

    urd_timer u_ds_timer
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(ds_start),
        .count(ds_cnt)
    );

    urd_timer u_filt_timer
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(filt_start),
        .count(filt_cnt)
    );

    // next state and timer starts
    always_comb
    begin
        state_nxt = state_r;
        rst_start = 1'b0;
        chirp_start = 1'b0;
        ds_start = 1'b0;
        filt_start = 1'b0;
        unique case (state_r)
            urd_pkg::URD_FS_RUN, urd_pkg::URD_FS_DEF:
            begin
                if (ls_changed && (ls == urd_pkg::URD_LS_SE0 || ls == urd_pkg::URD_LS_J))
                begin
                    state_nxt = urd_pkg::URD_FS_WAIT;
                    rst_start = 1'b1;
                end
            end
            urd_pkg::URD_FS_WAIT:
            begin
                if (ls_changed)
                    state_nxt = prev_r;
                else if (ls == urd_pkg::URD_LS_J && rst_cnt > SUSPEND_CYC)
                    state_nxt = urd_pkg::URD_SUSPEND;
                else if (ls == urd_pkg::URD_LS_SE0 && rst_cnt >= FS_WAIT_CYC)
                begin
                    state_nxt = urd_pkg::URD_CHIRP;
                    chirp_start = 1'b1;
                end
            end
            urd_pkg::URD_HS_RUN, urd_pkg::URD_HS_DEF:
            begin
                if (!hs_sync_r)
                begin
                    state_nxt = urd_pkg::URD_HS_WAIT;
                    rst_start = 1'b1;
                end
            end
            urd_pkg::URD_HS_WAIT:
            begin
                if (hs_sync_r)
                    state_nxt = prev_r;
                else if (rst_cnt > HS_REV_CYC)
                begin
                    state_nxt = urd_pkg::URD_SETTLE;
                    chirp_start = 1'b1;
                end
            end
            urd_pkg::URD_SETTLE:
            begin
                // the chirp timer times the settling; it restarts for the chirp
                if (chirp_cnt >= SETTLE_CYC)
                begin
                    if (ls == urd_pkg::URD_LS_SE0)
                    begin
                        state_nxt = urd_pkg::URD_CHIRP;
                        chirp_start = 1'b1;
                    end
                    else
                        state_nxt = urd_pkg::URD_SUSPEND;
                end
            end
            urd_pkg::URD_SUSPEND:
            begin
                // wake from suspend is outside this block
                state_nxt = urd_pkg::URD_SUSPEND;
            end
            urd_pkg::URD_CHIRP:
            begin
                if (chirp_cnt > UCH_CYC || rst_cnt > UCHEND_CYC)
                begin
                    state_nxt = urd_pkg::URD_DS_K;
                    ds_start = 1'b1;
                    filt_start = 1'b1;
                end
            end
            urd_pkg::URD_DS_K:
            begin
                if (ds_timeout)
                    state_nxt = urd_pkg::URD_FS_DEF;
                else if (ls != urd_pkg::URD_LS_K)
                    filt_start = 1'b1;
                else if (filt_ok)
                begin
                    state_nxt = urd_pkg::URD_DS_J;
                    filt_start = 1'b1;
                end
            end
            urd_pkg::URD_DS_J:
            begin
                if (ds_timeout)
                    state_nxt = urd_pkg::URD_FS_DEF;
                else if (ls != urd_pkg::URD_LS_J)
                    filt_start = 1'b1;
                else if (filt_ok)
                begin
                    filt_start = 1'b1;
                    if (kj_cnt_r == KJ_NEEDED - 2'd1)
                        state_nxt = urd_pkg::URD_HS_DEF;
                    else
                        state_nxt = urd_pkg::URD_DS_K;
                end
            end
            default:
                state_nxt = urd_pkg::URD_FS_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= urd_pkg::URD_FS_RUN;
            prev_r <= urd_pkg::URD_FS_RUN;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt == urd_pkg::URD_FS_WAIT || state_nxt == urd_pkg::URD_HS_WAIT)
            begin
                if (state_r != urd_pkg::URD_FS_WAIT && state_r != urd_pkg::URD_HS_WAIT)
                    prev_r <= state_r;
            end
        end
    end

    // k-j transition count
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            kj_cnt_r <= 2'd0;
        else if (state_r == urd_pkg::URD_CHIRP)
            kj_cnt_r <= 2'd0;
        else if (state_r == urd_pkg::URD_DS_J && state_nxt == urd_pkg::URD_DS_K)
            kj_cnt_r <= kj_cnt_r + 2'd1;
    end

    // transceiver controls, registered so nothing glitches onto the pins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            xcvr_r <= 3'h2;
        else
        begin
            if (state_nxt == urd_pkg::URD_SETTLE)
            begin
                xcvr_r.hs_term_en <= 1'b0;
                xcvr_r.dp_pullup_en <= 1'b1;
            end
            else if (state_nxt == urd_pkg::URD_HS_DEF && state_r == urd_pkg::URD_DS_J)
            begin
                xcvr_r.hs_term_en <= 1'b1;
                xcvr_r.dp_pullup_en <= 1'b0;
            end
            else if (state_nxt == urd_pkg::URD_SUSPEND && state_r == urd_pkg::URD_SETTLE
                     && ls == urd_pkg::URD_LS_K)
            begin
                xcvr_r.hs_term_en <= 1'b1;
                xcvr_r.dp_pullup_en <= 1'b0;
            end
            xcvr_r.chirp_k_drive <= (state_nxt == urd_pkg::URD_CHIRP);
        end
    end

    // status flags
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            stat_r <= '0;
        else
        begin
            stat_r.suspended <= (state_nxt == urd_pkg::URD_SUSPEND);
            stat_r.resume_req <= (state_r == urd_pkg::URD_SETTLE)
                && (state_nxt == urd_pkg::URD_SUSPEND) && (ls == urd_pkg::URD_LS_K);
            stat_r.fs_default <= (state_nxt == urd_pkg::URD_FS_DEF);
            stat_r.hs_default <= (state_nxt == urd_pkg::URD_HS_DEF);
            if (state_r == urd_pkg::URD_CHIRP)
                stat_r.reset_done <= 1'b0;
            else if (state_r == urd_pkg::URD_FS_DEF && ls_changed
                     && ls_prev_r == 2'b00 && ls == urd_pkg::URD_LS_J)
                stat_r.reset_done <= 1'b1;
            else if (state_r == urd_pkg::URD_HS_DEF && pkt_sync_r)
                stat_r.reset_done <= 1'b1;
        end
    end
endmodule

// File: dv/urd_top_props.sv
// concurrent checks on the ports of the reset detection and handshake block
`include "urd_params.svh"
module urd_top_props
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] line_state,
    input wire logic hs_mode_in,
    input wire logic packet_rx,
    input urd_pkg::urd_xcvr_s xcvr_r,
    input urd_pkg::urd_stat_s stat_r
);
    localparam int WAIT_CYC = `URD_FS_RST_WAIT_CYC;
    localparam int UCH_CYC = `URD_UCH_CYC;
    localparam int END_CYC = `URD_UCHEND_CYC;
    localparam int FILT_CYC = `URD_FILT_CYC;
    int unsigned se0_r;
    int unsigned chirp_r;
    int unsigned post_r;
    int unsigned run_r;
    int unsigned kj_r;
    logic [1:0] prev_r;
    logic k_seen_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            se0_r <= 0;
            chirp_r <= 0;
            post_r <= 0;
        end
        else
        begin
            se0_r <= (line_state == 2'h0) ? se0_r + 1 : 0;
            chirp_r <= xcvr_r.chirp_k_drive ? chirp_r + 1 : 0;
            post_r <= xcvr_r.chirp_k_drive ? 0 : post_r + 1;
        end
    end
    // the hub's first k runs on from the device chirp, so >= and not == on the filter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_r <= 2'h0;
            run_r <= 0;
            k_seen_r <= 1'b0;
            kj_r <= 0;
        end
        else
        begin
            prev_r <= line_state;
            run_r <= (line_state == prev_r) ? run_r + 1 : 0;
            if (xcvr_r.chirp_k_drive)
            begin
                kj_r <= 0;
                k_seen_r <= 1'b0;
            end
            else if (run_r >= FILT_CYC && prev_r == 2'h2)
                k_seen_r <= 1'b1;
            else if (run_r >= FILT_CYC && prev_r == 2'h1 && k_seen_r)
            begin
                k_seen_r <= 1'b0;
                kj_r <= kj_r + 1;
            end
        end
    end
    chk_chirp_after_se0: assert property ($rose(xcvr_r.chirp_k_drive) |-> se0_r >= WAIT_CYC)
        else $error("chirp began without a full se0 wait");
    chk_chirp_min_len: assert property ($fell(xcvr_r.chirp_k_drive) |-> chirp_r >= UCH_CYC)
        else $error("upstream chirp too short");
    chk_chirp_end_lim: assert property ($fell(xcvr_r.chirp_k_drive) |-> chirp_r + WAIT_CYC <= END_CYC)
        else $error("upstream chirp ran past its end limit");
    chk_hs_after_kj: assert property ($rose(stat_r.hs_default) |-> kj_r >= 3)
        else $error("high speed chosen before three k-j transitions");
    chk_hs_terms_on: assert property ($rose(stat_r.hs_default) |-> ##[0:1] xcvr_r.hs_term_en && !xcvr_r.dp_pullup_en)
        else $error("terminations not switched on high speed entry");
    // window is 1.0 ms to 2.5 ms at 100 MHz
    chk_fs_timeout_win: assert property ($rose(stat_r.fs_default) |-> post_r inside {[100000:250000]} && xcvr_r.dp_pullup_en)
        else $error("full speed fallback outside its timeout window");
    chk_fs_reset_end: assert property (stat_r.fs_default && !stat_r.reset_done && $past(line_state) == 2'h0 && line_state == 2'h1 |-> ##[1:6] stat_r.reset_done)
        else $error("full speed reset did not end on idle");
    chk_hs_reset_end: assert property (stat_r.hs_default && !stat_r.reset_done && packet_rx |-> ##[1:6] stat_r.reset_done)
        else $error("high speed reset did not end on packet");
    // idle after the fs outcome restarts detection, so the default flag drops with the same edge
    chk_done_cause: assert property ($rose(stat_r.reset_done) |-> $past(stat_r.fs_default) || $past(stat_r.hs_default))
        else $error("reset ended outside a default state");
    cov_hs: cover property ($rose(stat_r.hs_default));
    cov_fs: cover property ($rose(stat_r.fs_default));
    cov_done: cover property ($rose(stat_r.reset_done));
endmodule

bind urd_top urd_top_props urd_top_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .line_state(line_state), .hs_mode_in(hs_mode_in), .packet_rx(packet_rx),
    .xcvr_r(xcvr_r), .stat_r(stat_r));

// File: dv/urd_hub_model.sv
// behavioural hub port: drives reset se0 and answers a device chirp with k/j chirps
module urd_hub_model
(
    input wire logic sys_clk,
    input wire logic reset_req,
    input wire logic [2:0] pairs,
    input wire logic chirp_k_in,
    output logic [1:0] line_state
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BIT_CYC = 5000; // 50 us per chirp bit
    int unsigned cnt = 0;
    int unsigned bits = 0;
    logic armed = 1'b0;
    initial line_state = 2'h1;
    always @(posedge sys_clk)
    begin
        if (!reset_req)
        begin
            line_state <= 2'h1;
            armed <= 1'b0;
            bits <= 0;
        end
        else if (chirp_k_in)
        begin
            line_state <= 2'h2;
            armed <= 1'b1;
            cnt <= 0;
        end
        else if (armed && bits < 2 * pairs)
        begin
            line_state <= bits[0] ? 2'h1 : 2'h2; // k first, then j, alternating
            cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
            if (cnt == BIT_CYC - 1)
                bits <= bits + 1;
        end
        else
            line_state <= 2'h0; // se0 to the end of reset
    end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the reset detection and handshake block
`include "urd_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hs_mode_in = 1'b0;
    logic packet_rx = 1'b0;
    logic reset_req = 1'b0;
    logic [2:0] pairs = 3'h0;
    logic [1:0] line_state;
    urd_pkg::urd_xcvr_s xcvr_r;
    urd_pkg::urd_stat_s stat_r;
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    int up_n;
    int len_n;
    always #5 sys_clk = ~sys_clk;
    urd_hub_model urd_hub_model_i (.sys_clk(sys_clk), .reset_req(reset_req), .pairs(pairs),
        .chirp_k_in(xcvr_r.chirp_k_drive), .line_state(line_state));
    urd_top urd_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .line_state(line_state),
        .hs_mode_in(hs_mode_in), .packet_rx(packet_rx), .xcvr_r(xcvr_r), .stat_r(stat_r));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    // hub asserts reset; measure wait to chirp start and chirp length
    task automatic run_chirp;
        reset_req = 1'b1;
        for (n = 0; n < 12000 && xcvr_r.chirp_k_drive !== 1'b1; n++) step(1);
        up_n = n;
        for (n = 0; n < 160000 && xcvr_r.chirp_k_drive !== 1'b0; n++) step(1);
        len_n = n;
        check(up_n >= `URD_FS_RST_WAIT_CYC && up_n < 12000, 32'h1);
        check(len_n >= 100000 && len_n < 160000, 32'h1);
    endtask
    task automatic t_idle;
        step(20000);
        check(xcvr_r, 32'h2);
        check(stat_r, 32'h0);
    endtask
    task automatic t_short_se0;
        reset_req = 1'b1;
        step(9000);
        reset_req = 1'b0;
        for (n = 0; n < 12000 && xcvr_r.chirp_k_drive !== 1'b1; n++) step(1);
        check(n, 12000);
    endtask
    task automatic t_hs;
        pairs = 3'h3;
        // bus activity keeps the hs default state from starting a new detection
        hs_mode_in = 1'b1;
        run_chirp();
        for (n = 0; n < 40000 && stat_r.hs_default !== 1'b1; n++) step(1);
        // third j settles 5 bits of 5000 plus the filter after the chirp
        check(n >= 25250 && n < 40000, 32'h1);
        check(xcvr_r, 32'h4);
        check(stat_r.reset_done, 32'h0);
        packet_rx = 1'b1;
        step(1);
        packet_rx = 1'b0;
        for (n = 0; n < 20 && stat_r.reset_done !== 1'b1; n++) step(1);
        check(n < 20, 32'h1);
    endtask
    task automatic t_fs;
        rst_n = 1'b0;
        reset_req = 1'b0;
        hs_mode_in = 1'b0;
        pairs = 3'h2;
        step(10);
        rst_n = 1'b1;
        step(10);
        run_chirp();
        for (n = 0; n < 260000 && stat_r.fs_default !== 1'b1; n++) step(1);
        check(n >= 100000 && n <= 250000, 32'h1);
        check(xcvr_r, 32'h2);
        check(stat_r.hs_default, 32'h0);
        step(100);
        check(stat_r.reset_done, 32'h0);
        reset_req = 1'b0;
        for (n = 0; n < 20 && stat_r.reset_done !== 1'b1; n++) step(1);
        check(n < 20, 32'h1);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        step(10);
        rst_n = 1'b1;
        t_idle();
        t_short_se0();
        t_hs();
        t_fs();
        complete_run();
    end
    // the counts are fixed macros, so the run needs about 6 ms of bus time
    initial
    begin
        #7000000;
        error_cnt++;
        complete_run();
    end
endmodule
